// ### hdl/sei_consts.svh
//------------------------------------------------------------------------------
// Behaviour
// (RULE1) master with select as input: select sampled low sets mode fault flag
// (RULE2) mode fault clears the controller enable bit, shutting the controller down
// (RULE3) software reprograms the controller configuration after clearing mode fault
// (RULE4) re-enabled after mode fault: transfers work, flag stays until cleared
// (RULE5) slave: select rising during a frame sets the select error flag
// (RULE6) select error aborts the current frame and deselects the slave
// (RULE7) select low again resumes transfers; select error flag stays until cleared
// (RULE8) frame completes while receive full still set: set overrun flag
// (RULE9) overrun: new frame replaces the buffered receive word
// (RULE10) slave: frame starts with empty transmit buffer: set underrun flag
// (RULE11) after overrun or underrun transfers go on; flags stay until cleared
// (RULE12) edge and error flags clear only by writing zero to their clear bit
// (RULE13) eight interrupt sources, each flag gated by its enable bit
// (RULE14) all enabled sources ORed onto one interrupt line
// (RULE15) select falling edge sets fall flag, rising edge sets rise flag
// (RULE16) service routine checks, handles and clears flags before returning
// (RULE17) transmit dma enabled and transmit buffer empty: transmit dma request
// (RULE18) transmit and receive dma requests are separate outputs
// (RULE19) dma engine writes one frame per transmit request until count done
// (RULE20) software waits for busy clear before disabling the controller
// (RULE21) receive dma enabled and receive buffer full: receive dma request
// (RULE22) transmit empty set on move into shifter, cleared by data write
// (RULE23) receive full set when completed frame moves into the data register
// (RULE24) hardware set and software clear in one cycle: set wins
// (RULE25) flags, interrupt enables and dma enables are zero after reset
//------------------------------------------------------------------------------
`ifndef SEI_CONSTS_SVH
`define SEI_CONSTS_SVH

//------------------------------------------------------------------------------
// flag bit positions, shared by status, enable and clear words
//------------------------------------------------------------------------------
`define SEI_NUM_FLAGS      8
`define SEI_BIT_TX_EMPTY   0
`define SEI_BIT_RX_FULL    1
`define SEI_BIT_SEL_FALL   2
`define SEI_BIT_SEL_RISE   3
`define SEI_BIT_UNDERRUN   4
`define SEI_BIT_OVERRUN    5
`define SEI_BIT_SEL_ERR    6
`define SEI_BIT_MODE_FAULT 7

//------------------------------------------------------------------------------
// reset values
//------------------------------------------------------------------------------
`define SEI_FLAGS_RST      8'h00
`define SEI_IER_RST        8'h00
`define SEI_CS_IDLE        1'h1
`define SEI_DATA_W         16

`endif

// ### hdl/sei_pkg.sv
package sei_pkg;

  // slave selection tracking
  typedef enum logic [0:0]
  {
    SEI_SEL_IDLE,
    SEI_SEL_ACTIVE
  } sei_sel_state_t;

endpackage

// ### hdl/sei_sync2.sv
`timescale 1ns/1ps
`default_nettype none

module sei_sync2
#(
  parameter logic RST_VAL = 1'b0
)
(
  input  wire logic mclk_in,
  input  wire logic rst_n_in,
  input  wire logic ce_in,
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      meta_reg <= RST_VAL;
      sync_out <= RST_VAL;
    end
    else if (ce_in)
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

`default_nettype wire

// ### hdl/sei_flag_cell.sv
`timescale 1ns/1ps
`default_nettype none

module sei_flag_cell
(
  input  wire logic mclk_in,
  input  wire logic rst_n_in,
  input  wire logic ce_in,
  input  wire logic set_in,
  input  wire logic clr_in,
  output logic      flag_out
);

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      flag_out <= 1'b0; // RULE25
    else if (ce_in)
    begin
      if (set_in)
        flag_out <= 1'b1; // RULE24
      else if (clr_in)
        flag_out <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ### hdl/sei_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "sei_consts.svh"

module sei_ctrl
#(
  parameter int DATA_W = `SEI_DATA_W
)
(
  input  wire logic                      mclk_in,
  input  wire logic                      rst_n_in,
  input  wire logic                      ce_in,
  // configuration
  input  wire logic                      master_mode_in,
  input  wire logic                      cs_is_input_in,
  input  wire logic                      enable_wr_in,
  input  wire logic                      enable_val_in,
  output logic                           ctrl_enable_out,
  // select pin, asynchronous
  input  wire logic                      cs_pin_in,
  // data register access
  input  wire logic                      dr_wr_in,
  input  wire logic [DATA_W-1:0]         dr_wdata_in,
  input  wire logic                      dr_rd_in,
  output logic [DATA_W-1:0]              rx_data_out,
  // shift engine side
  input  wire logic                      tx_load_in,
  output logic [DATA_W-1:0]              tx_word_out,
  input  wire logic                      frame_start_in,
  input  wire logic                      frame_active_in,
  input  wire logic                      rx_done_in,
  input  wire logic [DATA_W-1:0]         rx_shift_word_in,
  output logic                           frame_abort_out,
  output logic                           slave_selected_out,
  // flags, enables, clears
  input  wire logic                      icr_wr_in,
  input  wire logic [`SEI_NUM_FLAGS-1:0] icr_data_in,
  input  wire logic                      ier_wr_in,
  input  wire logic [`SEI_NUM_FLAGS-1:0] ier_data_in,
  output logic [`SEI_NUM_FLAGS-1:0]      ier_out,
  output logic [`SEI_NUM_FLAGS-1:0]      status_out,
  output logic                           cs_level_out,
  output logic                           busy_out,
  output logic                           irq_out,
  // dma
  input  wire logic                      dma_cfg_wr_in,
  input  wire logic                      tx_dma_enable_in,
  input  wire logic                      rx_dma_enable_in,
  output logic                           tx_dma_req_out,
  output logic                           rx_dma_req_out
);

  //----------------------------------------------------------------------------
  // helpers
  //----------------------------------------------------------------------------

  // a zero written to a flag's position in the clear word clears that flag; tx_empty ignores the clear word
  function automatic logic icr_clears(input logic                      wr,
                                      input logic [`SEI_NUM_FLAGS-1:0] data,
                                      input int unsigned               pos);
    icr_clears = wr & ~data[pos];
  endfunction

  //----------------------------------------------------------------------------
  // declarations
  //----------------------------------------------------------------------------

  logic                          cs_sync;
  logic                          cs_prev_reg;
  logic                          cs_fall;
  logic                          cs_rise;
  logic                          enable_reg;
  logic                          enable_next;
  logic [DATA_W-1:0]             tx_buf_reg;
  logic [DATA_W-1:0]             rx_buf_reg;
  logic [`SEI_NUM_FLAGS-1:0]     flag_set;
  logic [`SEI_NUM_FLAGS-1:0]     flag_clr;
  logic [`SEI_NUM_FLAGS-1:0]     flags;
  logic [`SEI_NUM_FLAGS-1:0]     ier_reg;
  logic                          tx_dma_enable_reg;
  logic                          rx_dma_enable_reg;
  logic                          irq_reg;
  logic                          abort_reg;
  logic                          mode_fault_cond;
  logic                          sel_err_event;
  logic                          underrun_event;
  logic                          overrun_event;
  logic                          rx_full_clear;
  sei_pkg::sei_sel_state_t       sel_state_reg;
  sei_pkg::sei_sel_state_t       sel_state_next;

  //----------------------------------------------------------------------------
  // select pin synchronisation and edge detection
  //----------------------------------------------------------------------------

  sei_sync2
  #(
    .RST_VAL (`SEI_CS_IDLE)
  )
  u_cs_sync
  (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .ce_in    (ce_in),
    .async_in (cs_pin_in),
    .sync_out (cs_sync)
  );

  // edges are taken from the synchronised copy only, never the first stage
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      cs_prev_reg <= `SEI_CS_IDLE;
    else if (ce_in)
      cs_prev_reg <= cs_sync;
  end

  assign cs_fall = cs_prev_reg & ~cs_sync;
  assign cs_rise = ~cs_prev_reg & cs_sync;

  //----------------------------------------------------------------------------
  // error event detection
  //----------------------------------------------------------------------------

  // level condition: the other master keeps the bus as long as select is low
  assign mode_fault_cond = master_mode_in & cs_is_input_in & ~cs_sync; // RULE1

  // only a frame that is really shifting can be corrupted by a release
  assign sel_err_event = ~master_mode_in & cs_rise & frame_active_in; // RULE5

  assign underrun_event = ~master_mode_in & frame_start_in
                        & flags[`SEI_BIT_TX_EMPTY]; // RULE10

  // a read in the same cycle consumes the old word, so no overrun then
  assign rx_full_clear = dr_rd_in | icr_clears(icr_wr_in, icr_data_in, `SEI_BIT_RX_FULL);
  assign overrun_event = rx_done_in & flags[`SEI_BIT_RX_FULL] & ~rx_full_clear; // RULE8

  //----------------------------------------------------------------------------
  // controller enable
  //----------------------------------------------------------------------------

  always_comb
  begin
    enable_next = enable_reg;
    if (enable_wr_in)
      enable_next = enable_val_in;
    // hardware shutdown overrides a software enable in the same cycle
    if (mode_fault_cond)
      enable_next = 1'b0; // RULE2
  end

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      enable_reg <= 1'b0;
    else if (ce_in)
      enable_reg <= enable_next; // RULE4
  end

  assign ctrl_enable_out = enable_reg;

  //----------------------------------------------------------------------------
  // slave selection state
  //----------------------------------------------------------------------------

  always_comb
  begin
    sel_state_next = sel_state_reg;
    case (sel_state_reg)
      sei_pkg::SEI_SEL_IDLE:
      begin
        if (~master_mode_in & cs_fall)
          sel_state_next = sei_pkg::SEI_SEL_ACTIVE; // RULE7
      end
      sei_pkg::SEI_SEL_ACTIVE:
      begin
        if (master_mode_in | cs_rise | sel_err_event)
          sel_state_next = sei_pkg::SEI_SEL_IDLE; // RULE6
      end
      default:
        sel_state_next = sei_pkg::SEI_SEL_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      sel_state_reg <= sei_pkg::SEI_SEL_IDLE;
    else if (ce_in)
      sel_state_reg <= sel_state_next;
  end

  assign slave_selected_out = (sel_state_reg == sei_pkg::SEI_SEL_ACTIVE);

  // one-cycle pulse telling the shifter to drop the corrupted frame
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      abort_reg <= 1'b0;
    else if (ce_in)
      abort_reg <= sel_err_event; // RULE6
  end

  assign frame_abort_out = abort_reg;

  //----------------------------------------------------------------------------
  // data buffers
  //----------------------------------------------------------------------------

  // the buffer keeps its word after the shifter takes it; tx_empty tells the two apart
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      tx_buf_reg <= '0;
    else if (ce_in && dr_wr_in)
      tx_buf_reg <= dr_wdata_in;
  end

  assign tx_word_out = tx_buf_reg;

  // a finished frame always lands, overwriting an unread word on overrun
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rx_buf_reg <= '0;
    else if (ce_in && rx_done_in)
      rx_buf_reg <= rx_shift_word_in; // RULE9
  end

  assign rx_data_out = rx_buf_reg;

  //----------------------------------------------------------------------------
  // flag set and clear terms
  //----------------------------------------------------------------------------

  always_comb
  begin
    flag_set                       = '0;
    flag_set[`SEI_BIT_TX_EMPTY]    = tx_load_in; // RULE22
    flag_set[`SEI_BIT_RX_FULL]     = rx_done_in; // RULE23
    flag_set[`SEI_BIT_SEL_FALL]    = cs_fall; // RULE15
    flag_set[`SEI_BIT_SEL_RISE]    = cs_rise; // RULE15
    flag_set[`SEI_BIT_UNDERRUN]    = underrun_event; // RULE11
    flag_set[`SEI_BIT_OVERRUN]     = overrun_event; // RULE11
    flag_set[`SEI_BIT_SEL_ERR]     = sel_err_event; // RULE7
    flag_set[`SEI_BIT_MODE_FAULT]  = mode_fault_cond; // RULE4
  end

  always_comb
  begin
    flag_clr                       = '0;
    flag_clr[`SEI_BIT_TX_EMPTY]    = dr_wr_in; // RULE22
    flag_clr[`SEI_BIT_RX_FULL]     = rx_full_clear; // RULE8
    flag_clr[`SEI_BIT_SEL_FALL]    = icr_clears(icr_wr_in, icr_data_in, `SEI_BIT_SEL_FALL); // RULE12
    flag_clr[`SEI_BIT_SEL_RISE]    = icr_clears(icr_wr_in, icr_data_in, `SEI_BIT_SEL_RISE); // RULE12
    flag_clr[`SEI_BIT_UNDERRUN]    = icr_clears(icr_wr_in, icr_data_in, `SEI_BIT_UNDERRUN); // RULE12
    flag_clr[`SEI_BIT_OVERRUN]     = icr_clears(icr_wr_in, icr_data_in, `SEI_BIT_OVERRUN); // RULE12
    flag_clr[`SEI_BIT_SEL_ERR]     = icr_clears(icr_wr_in, icr_data_in, `SEI_BIT_SEL_ERR); // RULE12
    flag_clr[`SEI_BIT_MODE_FAULT]  = icr_clears(icr_wr_in, icr_data_in, `SEI_BIT_MODE_FAULT); // RULE12
  end

  //----------------------------------------------------------------------------
  // sticky flags, set wins over clear
  //----------------------------------------------------------------------------

  genvar gi;
  generate
    for (gi = 0; gi < `SEI_NUM_FLAGS; gi++)
    begin : g_flag
      sei_flag_cell u_flag
      (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n_in),
        .ce_in    (ce_in),
        .set_in   (flag_set[gi]),
        .clr_in   (flag_clr[gi]),
        .flag_out (flags[gi])
      );
    end
  endgenerate

  //----------------------------------------------------------------------------
  // status outputs
  //----------------------------------------------------------------------------

  assign status_out   = flags;
  assign cs_level_out = cs_sync;
  // busy while a word waits in the buffer or the shifter is working
  assign busy_out     = ~flags[`SEI_BIT_TX_EMPTY] | frame_active_in;

  //----------------------------------------------------------------------------
  // interrupt enables and the single request line
  //----------------------------------------------------------------------------

  // enables are written as a whole word; software keeps its own copy to change one bit
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      ier_reg <= `SEI_IER_RST; // RULE25
    else if (ce_in && ier_wr_in)
      ier_reg <= ier_data_in;
  end

  assign ier_out = ier_reg;

  // registered so the line is glitch free toward the interrupt controller
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      irq_reg <= 1'b0;
    else if (ce_in)
      irq_reg <= |(flags & ier_reg); // RULE13 RULE14
  end

  assign irq_out = irq_reg;

  //----------------------------------------------------------------------------
  // dma requests
  //----------------------------------------------------------------------------

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      tx_dma_enable_reg <= 1'b0; // RULE25
      rx_dma_enable_reg <= 1'b0; // RULE25
    end
    else if (ce_in && dma_cfg_wr_in)
    begin
      tx_dma_enable_reg <= tx_dma_enable_in;
      rx_dma_enable_reg <= rx_dma_enable_in;
    end
  end

  // level requests: each drops as soon as the engine services the buffer
  // no tx request after reset until the shifter has taken its first word
  assign tx_dma_req_out = tx_dma_enable_reg & flags[`SEI_BIT_TX_EMPTY]; // RULE17 RULE18
  assign rx_dma_req_out = rx_dma_enable_reg & flags[`SEI_BIT_RX_FULL]; // RULE21 RULE18

endmodule

`default_nettype wire

// ### bench/sei_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none

module sei_ctrl_properties
#(
  parameter int DATA_W = 16
)
(
  input wire logic              mclk_in,
  input wire logic              rst_n_in,
  input wire logic              ce_in,
  input wire logic              master_mode_in,
  input wire logic              cs_is_input_in,
  input wire logic              ctrl_enable_out,
  input wire logic              dr_wr_in,
  input wire logic [DATA_W-1:0] dr_wdata_in,
  input wire logic              dr_rd_in,
  input wire logic [DATA_W-1:0] rx_data_out,
  input wire logic              tx_load_in,
  input wire logic [DATA_W-1:0] tx_word_out,
  input wire logic              frame_start_in,
  input wire logic              frame_active_in,
  input wire logic              rx_done_in,
  input wire logic [DATA_W-1:0] rx_shift_word_in,
  input wire logic              slave_selected_out,
  input wire logic              frame_abort_out,
  input wire logic              icr_wr_in,
  input wire logic [7:0]        icr_data_in,
  input wire logic [7:0]        ier_out,
  input wire logic [7:0]        status_out,
  input wire logic              cs_level_out,
  input wire logic              irq_out,
  input wire logic              dma_cfg_wr_in,
  input wire logic              tx_dma_enable_in,
  input wire logic              rx_dma_enable_in,
  input wire logic              tx_dma_req_out,
  input wire logic              rx_dma_req_out
);
  logic irq_cause;
  assign irq_cause = |(status_out & ier_out);

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);

  //----------------------------------------------------------------------------
  // select error: cut mid frame, then slave dropped
  //----------------------------------------------------------------------------
  sequence cut_mid_frame;
    ce_in && !master_mode_in && frame_active_in && $rose(cs_level_out);
  endsequence
  sequence slave_dropped;
    ##1 (status_out[6] && frame_abort_out && !slave_selected_out) ##1 !frame_abort_out;
  endsequence

  a_sel_err_abort: assert property (cut_mid_frame |-> slave_dropped)
    else $error("select error not flagged");
  a_rx_full_set: assert property (ce_in && rx_done_in |=> status_out[1])
    else $error("rx full not set");
  a_overrun_set: assert property (ce_in && rx_done_in && status_out[1] && !dr_rd_in
    && !(icr_wr_in && !icr_data_in[1]) |=> status_out[5] && rx_data_out == $past(rx_shift_word_in))
    else $error("overrun not handled");
  a_flags_sticky: assert property (ce_in && !icr_wr_in
    |=> (status_out[7:2] & $past(status_out[7:2])) == $past(status_out[7:2]))
    else $error("flag dropped without clear");
  a_clear_overrun: assert property (ce_in && icr_wr_in && !icr_data_in[5] && !rx_done_in
    |=> !status_out[5])
    else $error("overrun clear ignored");
  a_irq_merge: assert property (ce_in |=> irq_out == $past(irq_cause))
    else $error("irq not OR of enabled flags");
  a_tx_empty_set: assert property (ce_in && tx_load_in |=> status_out[0])
    else $error("tx empty not set");
  a_tx_write: assert property (ce_in && dr_wr_in && !tx_load_in
    |=> !status_out[0] && tx_word_out == $past(dr_wdata_in))
    else $error("data write not taken");
  a_dma_gated: assert property (!(tx_dma_req_out && !status_out[0])
    && !(rx_dma_req_out && !status_out[1]))
    else $error("dma request without cause");
  a_dma_follow: assert property (ce_in && dma_cfg_wr_in && tx_dma_enable_in && rx_dma_enable_in
    |=> tx_dma_req_out == status_out[0] && rx_dma_req_out == status_out[1])
    else $error("dma request not following flags");
  a_mode_fault: assert property (ce_in && master_mode_in && cs_is_input_in && !cs_level_out
    |-> ##[1:2] (status_out[7] && !ctrl_enable_out))
    else $error("mode fault not handled");
  a_sel_fall: assert property (ce_in && $fell(cs_level_out) |-> ##[0:1] status_out[2])
    else $error("select fall flag missing");
  a_underrun_set: assert property (ce_in && !master_mode_in && frame_start_in && status_out[0]
    |=> status_out[4])
    else $error("underrun not flagged");
endmodule

bind sei_ctrl sei_ctrl_properties #(.DATA_W(DATA_W)) u_props (.*);

`default_nettype wire

// ### bench/sei_far_end.sv
`timescale 1ns/1ps
`default_nettype none

module sei_far_end
#(
  parameter int DATA_W   = 16,
  parameter int BITS     = 4,
  parameter int LINK_CYC = 16
)
(
  input  wire logic          mclk_in,
  output logic               cs_pin_out,
  output logic               frame_start_out,
  output logic               frame_active_out,
  output logic               tx_load_out,
  output logic               rx_done_out,
  output logic [DATA_W-1:0]  rx_word_out
);
  initial
  begin
    cs_pin_out = 1'h1;
    {frame_start_out, frame_active_out, tx_load_out, rx_done_out} = 4'h0;
    rx_word_out = '1;
  end

  task automatic set_cs(input logic v);
    @(posedge mclk_in);
    #1;
    cs_pin_out = v;
  endtask

  // one frame of BITS link periods; cut raises select halfway through
  task automatic run_frame(input logic [DATA_W-1:0] w, input logic cut);
    set_cs(1'h0);
    repeat (4) @(posedge mclk_in);
    #1;
    {frame_start_out, tx_load_out, frame_active_out} = 3'h7;
    @(posedge mclk_in);
    #1;
    {frame_start_out, tx_load_out} = 2'h0;
    repeat (cut ? BITS * LINK_CYC / 2 : BITS * LINK_CYC) @(posedge mclk_in);
    #1;
    if (cut)
    begin
      cs_pin_out = 1'h1;
      repeat (4) @(posedge mclk_in);
      #1;
      frame_active_out = 1'h0;
    end
    else
    begin
      frame_active_out = 1'h0;
      rx_done_out = 1'h1;
      rx_word_out = w;
      @(posedge mclk_in);
      #1;
      rx_done_out = 1'h0;
      // word no longer valid: show its inverse, not a stale copy
      rx_word_out = ~w;
      cs_pin_out = 1'h1;
    end
    repeat (6) @(posedge mclk_in);
    #1;
  endtask
endmodule

`default_nettype wire

// ### bench/tb_sei_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module tb_sei_ctrl;
  logic          mclk_in, rst_n_in, ce_in, master_mode_in, cs_is_input_in, enable_wr_in;
  logic          enable_val_in, ctrl_enable_out, cs_pin_in, dr_wr_in, dr_rd_in, tx_load_in;
  logic          frame_start_in, frame_active_in, rx_done_in, frame_abort_out, icr_wr_in;
  logic          slave_selected_out, ier_wr_in, cs_level_out, busy_out, irq_out, dma_cfg_wr_in;
  logic          tx_dma_enable_in, rx_dma_enable_in, tx_dma_req_out, rx_dma_req_out;
  logic [15:0]   dr_wdata_in, rx_data_out, tx_word_out, rx_shift_word_in, w;
  logic [7:0]    icr_data_in, ier_data_in, ier_out, status_out, ier_val, exp_st;
  logic [31:0]   rnd;
  int            err_total = 0;
  int            checks = 0;
  int            cyc = 0;

  sei_ctrl #(.DATA_W(16)) dut (.*);
  sei_far_end #(.DATA_W(16)) u_far (.mclk_in, .cs_pin_out(cs_pin_in),
    .frame_start_out(frame_start_in), .frame_active_out(frame_active_in),
    .tx_load_out(tx_load_in), .rx_done_out(rx_done_in), .rx_word_out(rx_shift_word_in));

  initial mclk_in = 1'h0;
  always #2 mclk_in = ~mclk_in;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic exp_irq(input logic [7:0] st, input logic [7:0] en);
    return |(st & en);
  endfunction
  // slave frame with no read and no write: overrun if still full, underrun if empty
  function automatic logic [7:0] frame_st(input logic [7:0] st);
    return st | 8'h0F | {2'h0, st[1], st[0], 4'h0};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask

  // software side: 0 data, 1 clear, 2 enables, 3 ctrl enable, 4 dma cfg, 5 read
  task automatic sw_write(input int kind, input logic [15:0] d);
    tick(1);
    case (kind)
      0: {dr_wr_in, dr_wdata_in} = {1'h1, d};
      1: {icr_wr_in, icr_data_in} = {1'h1, d[7:0]};
      2: {ier_wr_in, ier_data_in} = {1'h1, d[7:0]};
      3: {enable_wr_in, enable_val_in} = {1'h1, d[0]};
      4: {dma_cfg_wr_in, rx_dma_enable_in, tx_dma_enable_in} = {1'h1, d[1:0]};
      default: dr_rd_in = 1'h1;
    endcase
    tick(1);
    {dr_wr_in, icr_wr_in, ier_wr_in, enable_wr_in, dma_cfg_wr_in, dr_rd_in} = 6'h00;
  endtask

  always @(posedge mclk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      close_out();
    end
  end

  initial
  begin
    {ce_in, rst_n_in, master_mode_in, cs_is_input_in, enable_wr_in, enable_val_in} = 6'h20;
    {dr_wr_in, dr_rd_in, icr_wr_in, ier_wr_in, dma_cfg_wr_in} = 5'h00;
    {tx_dma_enable_in, rx_dma_enable_in, dr_wdata_in} = 18'h00000;
    {icr_data_in, ier_data_in} = 16'hFFFF;
    rnd = 32'h2288;
    tick(2);
    rst_n_in = 1'h1;
    check(status_out, 8'h00);
    check({ier_out, irq_out, tx_dma_req_out, rx_dma_req_out, ctrl_enable_out}, 12'h000);
    rnd = lfsr(rnd);
    ier_val = rnd[7:0] | 8'h30;
    sw_write(2, {8'h00, ier_val});
    sw_write(4, 16'h0003);
    check(ier_out, ier_val);
    exp_st = 8'h00;
    for (int i = 0; i < 3; i++)
    begin
      rnd = lfsr(rnd);
      w = rnd[15:0];
      exp_st = frame_st(exp_st);
      u_far.run_frame(w, 1'h0);
      check(status_out, exp_st);
      check(rx_data_out, w);
      check({irq_out, tx_dma_req_out, rx_dma_req_out}, {exp_irq(exp_st, ier_val), 2'h3});
    end
    sw_write(5, 16'h0000);
    check(status_out[1], 1'h0);
    sw_write(1, 16'h0001);
    tick(1);
    check({status_out, irq_out}, {8'h01, exp_irq(8'h01, ier_val)});
    for (int i = 0; i < 2; i++)
    begin
      rnd = lfsr(rnd);
      if (tx_dma_req_out === 1'h1)
        sw_write(0, rnd[15:0]);
      check({status_out[0], tx_dma_req_out, tx_word_out}, {2'h0, rnd[15:0]});
      u_far.run_frame(rnd[31:16], 1'h0);
    end
    check(status_out[4], 1'h0);
    fork
      u_far.run_frame(rnd[15:0], 1'h0);
      begin
        wait (rx_done_in === 1'h1);
        {icr_wr_in, icr_data_in} = {1'h1, 8'hFD};
        tick(1);
        icr_wr_in = 1'h0;
      end
    join
    check(status_out[1], 1'h1);
    u_far.run_frame(rnd[15:0], 1'h1);
    check({status_out[6], slave_selected_out}, 2'h2);
    rnd = lfsr(rnd);
    u_far.run_frame(rnd[15:0], 1'h0);
    check({status_out[6], status_out[1], rx_data_out}, {2'h3, rnd[15:0]});
    {master_mode_in, cs_is_input_in} = 2'h3;
    sw_write(3, 16'h0001);
    check(ctrl_enable_out, 1'h1);
    u_far.set_cs(1'h0);
    tick(5);
    check({status_out[7], ctrl_enable_out, cs_level_out}, 3'h4);
    u_far.set_cs(1'h1);
    tick(4);
    sw_write(3, 16'h0001);
    check({status_out[7], ctrl_enable_out, cs_level_out}, 3'h7);
    for (int k = 0; k < 50 && busy_out !== 1'h0; k++)
      tick(1);
    check(busy_out, 1'h0);
    sw_write(3, 16'h0000);
    ce_in = 1'h0;
    sw_write(1, 16'h0000);
    check(status_out[7], 1'h1);
    ce_in = 1'h1;
    sw_write(1, 16'h007F);
    {master_mode_in, cs_is_input_in} = 2'h2;
    check(status_out[7], 1'h0);
    u_far.set_cs(1'h0);
    tick(5);
    check(status_out[7], 1'h0);
    rst_n_in = 1'h0;
    tick(2);
    rst_n_in = 1'h1;
    check({status_out, ier_out}, 16'h0000);
    close_out();
  end
endmodule

`default_nettype wire
